// >>> common/tcc_pkg.sv
// Shared constants and types of the timer/counter channel
package tcc_pkg;
   // Register byte offsets
   localparam logic [7:0] TCC_CCR_OFS = 8'h00;
   localparam logic [7:0] TCC_CMR_OFS = 8'h04;
   localparam logic [7:0] TCC_CV_OFS = 8'h10;
   localparam logic [7:0] TCC_RA_OFS = 8'h14;
   localparam logic [7:0] TCC_RB_OFS = 8'h18;
   localparam logic [7:0] TCC_RC_OFS = 8'h1c;
   localparam logic [7:0] TCC_SR_OFS = 8'h20;
   localparam logic [7:0] TCC_BCR_OFS = 8'hc0;
   localparam logic [7:0] TCC_BMR_OFS = 8'hc4;
   // Channel control command bits
   localparam int TCC_CCR_ON = 0;
   localparam int TCC_CCR_OFF = 1;
   localparam int TCC_CCR_SWT = 2;
   localparam int TCC_BCR_SIM = 0;
   // Channel mode fields
   localparam int TCC_CMR_CLK = 0;
   localparam int TCC_CMR_INV = 3;
   localparam int TCC_CMR_GATE = 4;
   localparam int TCC_CMR_STOP = 6;
   localparam int TCC_CMR_DIS = 7;
   localparam int TCC_CMR_EDGE = 8;
   localparam int TCC_CMR_TSEL = 10;
   localparam int TCC_CMR_ESRC = 10;
   localparam int TCC_CMR_ETEN = 12;
   localparam int TCC_CMR_CTRG = 14;
   localparam int TCC_CMR_WAVE = 15;
   localparam int TCC_CMR_LDA = 16;
   localparam int TCC_CMR_LDB = 18;
   localparam int TCC_CMR_ACTS = 16;
   localparam logic [31:0] TCC_CMR_RST = 32'h0000_0000;
   localparam logic [5:0] TCC_BMR_RST = 6'h00;
   // Status bit positions
   localparam int TCC_SR_OVF = 0;
   localparam int TCC_SR_LOVR = 1;
   localparam int TCC_SR_CPA = 2;
   localparam int TCC_SR_CPB = 3;
   localparam int TCC_SR_CPC = 4;
   localparam int TCC_SR_LDA = 5;
   localparam int TCC_SR_LDB = 6;
   localparam int TCC_SR_ETRG = 7;
   localparam int TCC_SR_CLKON = 16;
   localparam int TCC_SR_STICKY = 8;
   localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
   localparam int TCC_DIV_W = 10;
   localparam int TCC_NSYNC = 8;
   typedef enum logic [1:0] {
      TCC_EDGE_NONE = 2'b00, TCC_EDGE_RISE = 2'b01,
      TCC_EDGE_FALL = 2'b10, TCC_EDGE_BOTH = 2'b11
   } tcc_edge_t;
   typedef enum logic [1:0] {
      TCC_ACT_NONE = 2'b00, TCC_ACT_SET = 2'b01,
      TCC_ACT_CLR = 2'b10, TCC_ACT_TOG = 2'b11
   } tcc_act_t;
   typedef enum logic {
      TCC_WAIT_A = 1'b0, TCC_WAIT_B = 1'b1
   } tcc_phase_t;
endpackage

// >>> logic/tcc_channel.sv
// One 16-bit timer/counter channel with its block registers, Wishbone slave
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/10ps
// Summary of operation
// - 16-bit counter increments on each rising edge of the conditioned clock.
// - Wrap from all ones to zero sets the overflow flag.
// - Counter readable live; after a trigger it zeroes on next clock edge.
// - Clock chosen from master clock /2,/8,/32,/128,/1024 or three external inputs.
// - Block mode routes each external input from its pin or a peer line A.
// - Clock inversion option; burst gating passes clock while chosen input high.
// - On and off commands enable clock; while off start and stop ignored.
// - Load B (capture) or compare C (waveform) may disable the clock.
// - Triggers start clock; load B or compare C may stop it, when enabled.
// - Mode bit selects capture (lines in) or waveform (A out, B out unless event).
// - Trigger zeroes counter and starts clock; soft and block-wide triggers.
// - Compare C match may act as a trigger in both modes.
// - Capture copies counter into A and B on chosen line A edges.
// - A loads first after trigger or B; B only after A.
// - Reloading an unread capture register overwrites it and flags overrun.
// - Capture trigger input is line A or B, edge selectable, zero disables.
// - Status event flags are sticky and clear on status read.
// - Waveform: A and B compares drive lines, C may drive both and set period.
// - Waveform event from line B or an external input, edge set, may trigger.
// - Output controller sets, clears or toggles lines per event.
// - Coinciding output events: soft trigger, event, compare C, then A or B.
module tcc_channel
   import tcc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] ext_clock_pin,
   input wire logic [2:0] peer_io_line_a,
   input wire logic io_line_a_i,
   output logic io_line_a_o,
   output logic io_line_a_oe,
   input wire logic io_line_b_i,
   output logic io_line_b_o,
   output logic io_line_b_oe
);
   logic [7:0] s1, s2, s3, lvl, lvl_d;
   logic [TCC_DIV_W-1:0] div;
   logic [31:0] cmr;
   logic [5:0] bmr;
   logic [15:0] cnt, ra, rb, rc;
   logic [7:0] sr;
   logic clk_en, clk_run, rst_pend, cond_d, cnt_upd, ra_unread, rb_unread;
   tcc_phase_t phase;
   logic [2:0] xc, xc_d;
   logic [3:0] gate_src;
   logic src, cond, clk_edge, cnt_step;
   logic wave, req, wr, rd, sr_read, sw_trig, ext_trig, evt, trig;
   logic cmp_a, cmp_b, cmp_c, ld_a, ld_b, stop_ev, dis_ev, on_cmd, off_cmd;
   logic [31:0] rdata;

   function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                     input logic prv);
      case (sel)
         TCC_EDGE_RISE: return cur & ~prv;
         TCC_EDGE_FALL: return ~cur & prv;
         TCC_EDGE_BOTH: return cur ^ prv;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic xc_pick(input logic [1:0] sel, input logic pin,
                                    input logic pa, input logic pb);
      case (sel)
         2'd0: return pin;
         2'd2: return pa;
         2'd3: return pb;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic act(input logic [1:0] a, input logic cur);
      case (a)
         TCC_ACT_SET: return 1'b1;
         TCC_ACT_CLR: return 1'b0;
         TCC_ACT_TOG: return ~cur;
         default: return cur;
      endcase
   endfunction

   // Acts order: [7:6] soft, [5:4] event, [3:2] compare C, [1:0] compare A/B
   function automatic logic out_next(input logic sw, input logic ev,
                                     input logic c, input logic x,
                                     input logic [7:0] a, input logic cur);
      if (sw) begin
         return act(a[7:6], cur);
      end else if (ev) begin
         return act(a[5:4], cur);
      end else if (c) begin
         return act(a[3:2], cur);
      end else if (x) begin
         return act(a[1:0], cur);
      end
      return cur;
   endfunction

   // Pins and peer lines: three flops, change accepted when last two agree
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         lvl_d <= '0;
      end else begin
         s1 <= {io_line_b_i, io_line_a_i, peer_io_line_a, ext_clock_pin};
         s2 <= s1;
         s3 <= s2;
         lvl_d <= lvl;
      end
   end

   generate
      for (genvar i = 0; i < TCC_NSYNC; i++) begin : g_flt
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               lvl[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               lvl[i] <= s3[i];
            end
         end
      end
   endgenerate

   always_comb begin
      xc[0] = xc_pick(bmr[1:0], lvl[0], lvl[4], lvl[5]);
      xc[1] = xc_pick(bmr[3:2], lvl[1], lvl[3], lvl[5]);
      xc[2] = xc_pick(bmr[5:4], lvl[2], lvl[3], lvl[4]);
      case (cmr[TCC_CMR_CLK +: 3])
         3'd0: src = div[0];
         3'd1: src = div[2];
         3'd2: src = div[4];
         3'd3: src = div[6];
         3'd4: src = div[9];
         3'd5: src = xc[0];
         3'd6: src = xc[1];
         default: src = xc[2];
      endcase
      // Gate select 0 picks the constant one, so no gating
      gate_src = {xc, 1'b1};
      cond = (src ^ cmr[TCC_CMR_INV]) & gate_src[cmr[TCC_CMR_GATE +: 2]];
   end

   assign clk_edge = cond & ~cond_d;
   assign cnt_step = clk_edge & clk_en & clk_run;
   assign wave = cmr[TCC_CMR_WAVE];

   // Bus decode: every access acks one cycle after the request appears
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign sr_read = rd & (wb_adr_i == TCC_SR_OFS);
   assign on_cmd = wr & wb_sel_i[0] & (wb_adr_i == TCC_CCR_OFS) & wb_dat_i[TCC_CCR_ON];
   assign off_cmd = wr & wb_sel_i[0] & (wb_adr_i == TCC_CCR_OFS) & wb_dat_i[TCC_CCR_OFF];
   assign sw_trig = wr & wb_sel_i[0] &
                    (((wb_adr_i == TCC_CCR_OFS) & wb_dat_i[TCC_CCR_SWT]) |
                     ((wb_adr_i == TCC_BCR_OFS) & wb_dat_i[TCC_BCR_SIM]));

   // Compares look at the counter value just after it moved
   assign cmp_a = cnt_upd & (cnt == ra) & wave;
   assign cmp_b = cnt_upd & (cnt == rb) & wave;
   assign cmp_c = cnt_upd & (cnt == rc);
   assign ld_a = ~wave & (phase == TCC_WAIT_A) &
                 edge_hit(cmr[TCC_CMR_LDA +: 2], lvl[6], lvl_d[6]);
   assign ld_b = ~wave & (phase == TCC_WAIT_B) &
                 edge_hit(cmr[TCC_CMR_LDB +: 2], lvl[6], lvl_d[6]);

   always_comb begin
      evt = 1'b0;
      if (wave) begin
         case (cmr[TCC_CMR_ESRC +: 2])
            2'd0: evt = edge_hit(cmr[TCC_CMR_EDGE +: 2], lvl[7], lvl_d[7]);
            2'd1: evt = edge_hit(cmr[TCC_CMR_EDGE +: 2], xc[0], xc_d[0]);
            2'd2: evt = edge_hit(cmr[TCC_CMR_EDGE +: 2], xc[1], xc_d[1]);
            default: evt = edge_hit(cmr[TCC_CMR_EDGE +: 2], xc[2], xc_d[2]);
         endcase
         ext_trig = evt & cmr[TCC_CMR_ETEN];
      end else if (cmr[TCC_CMR_TSEL]) begin
         ext_trig = edge_hit(cmr[TCC_CMR_EDGE +: 2], lvl[7], lvl_d[7]);
      end else begin
         ext_trig = edge_hit(cmr[TCC_CMR_EDGE +: 2], lvl[6], lvl_d[6]);
      end
      trig = sw_trig | ext_trig | (cmp_c & cmr[TCC_CMR_CTRG]);
      stop_ev = wave ? cmp_c & cmr[TCC_CMR_STOP] : ld_b & cmr[TCC_CMR_STOP];
      dis_ev = wave ? cmp_c & cmr[TCC_CMR_DIS] : ld_b & cmr[TCC_CMR_DIS];
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         div <= '0;
         cond_d <= 1'b0;
         xc_d <= '0;
      end else begin
         div <= div + 1'b1;
         cond_d <= cond;
         xc_d <= xc;
      end
   end

   // A peer line on the external input is only as fresh as the filter allows
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         clk_en <= 1'b0;
         clk_run <= 1'b0;
      end else begin
         if (off_cmd | dis_ev) begin
            clk_en <= 1'b0;
         end else if (on_cmd) begin
            clk_en <= 1'b1;
         end
         // Stop beats a coincident trigger so one-shot pulses end cleanly
         if (clk_en & stop_ev) begin
            clk_run <= 1'b0;
         end else if ((clk_en | on_cmd) & ~off_cmd & trig) begin
            clk_run <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt <= '0;
         rst_pend <= 1'b0;
         cnt_upd <= 1'b0;
      end else begin
         cnt_upd <= cnt_step;
         if (cnt_step) begin
            cnt <= rst_pend ? 16'h0000 : cnt + 16'h0001;
            rst_pend <= trig;
         end else if (trig) begin
            rst_pend <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         phase <= TCC_WAIT_A;
      end else if (trig) begin
         phase <= TCC_WAIT_A;
      end else if (ld_a) begin
         phase <= TCC_WAIT_B;
      end else if (ld_b) begin
         phase <= TCC_WAIT_A;
      end else begin
         phase <= phase;
      end
   end

   // Register file writes; capture registers are read only in capture mode
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cmr <= TCC_CMR_RST;
         bmr <= TCC_BMR_RST;
         ra <= '0;
         rb <= '0;
         rc <= '0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr & wb_sel_i[b] & (wb_adr_i == TCC_CMR_OFS)) begin
               cmr[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
         for (int b = 0; b < 2; b++) begin
            if (wr & wb_sel_i[b] & wave & (wb_adr_i == TCC_RA_OFS)) begin
               ra[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            if (wr & wb_sel_i[b] & wave & (wb_adr_i == TCC_RB_OFS)) begin
               rb[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
            if (wr & wb_sel_i[b] & (wb_adr_i == TCC_RC_OFS)) begin
               rc[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
         if (wr & wb_sel_i[0] & (wb_adr_i == TCC_BMR_OFS)) begin
            bmr <= wb_dat_i[5:0];
         end
         if (ld_a) begin
            ra <= cnt;
         end
         if (ld_b) begin
            rb <= cnt;
         end
      end
   end

   // Sticky flags; a new event in the clearing cycle survives
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sr <= '0;
         ra_unread <= 1'b0;
         rb_unread <= 1'b0;
      end else begin
         ra_unread <= ld_a | (ra_unread & ~(rd & (wb_adr_i == TCC_RA_OFS)));
         rb_unread <= ld_b | (rb_unread & ~(rd & (wb_adr_i == TCC_RB_OFS)));
         sr[TCC_SR_OVF] <= (cnt_step & ~rst_pend & (cnt == TCC_CNT_MAX)) |
                           (sr[TCC_SR_OVF] & ~sr_read);
         sr[TCC_SR_LOVR] <= (ld_a & ra_unread) | (ld_b & rb_unread) |
                            (sr[TCC_SR_LOVR] & ~sr_read);
         sr[TCC_SR_CPA] <= cmp_a | (sr[TCC_SR_CPA] & ~sr_read);
         sr[TCC_SR_CPB] <= cmp_b | (sr[TCC_SR_CPB] & ~sr_read);
         sr[TCC_SR_CPC] <= cmp_c | (sr[TCC_SR_CPC] & ~sr_read);
         sr[TCC_SR_LDA] <= ld_a | (sr[TCC_SR_LDA] & ~sr_read);
         sr[TCC_SR_LDB] <= ld_b | (sr[TCC_SR_LDB] & ~sr_read);
         sr[TCC_SR_ETRG] <= ext_trig | (sr[TCC_SR_ETRG] & ~sr_read);
      end
   end

   always_comb begin
      case (wb_adr_i)
         TCC_CMR_OFS: rdata = cmr;
         TCC_CV_OFS: rdata = {16'h0000, cnt};
         TCC_RA_OFS: rdata = {16'h0000, ra};
         TCC_RB_OFS: rdata = {16'h0000, rb};
         TCC_RC_OFS: rdata = {16'h0000, rc};
         TCC_SR_OFS: rdata = {15'h0000, clk_en, 8'h00, sr};
         TCC_BMR_OFS: rdata = {26'h0000000, bmr};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= rd ? rdata : 32'h0000_0000;
      end
   end

   // Output controller; line B drives only when not the event input
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         io_line_a_o <= 1'b0;
         io_line_b_o <= 1'b0;
         io_line_a_oe <= 1'b0;
         io_line_b_oe <= 1'b0;
      end else begin
         io_line_a_oe <= wave;
         io_line_b_oe <= wave & (cmr[TCC_CMR_ESRC +: 2] != 2'd0);
         if (wave) begin
            io_line_a_o <= out_next(sw_trig, evt, cmp_c, cmp_a,
               {cmr[TCC_CMR_ACTS+6 +: 2], cmr[TCC_CMR_ACTS+4 +: 2],
                cmr[TCC_CMR_ACTS+2 +: 2], cmr[TCC_CMR_ACTS +: 2]},
               io_line_a_o);
            if (cmr[TCC_CMR_ESRC +: 2] != 2'd0) begin
               io_line_b_o <= out_next(sw_trig, evt, cmp_c, cmp_b,
                  cmr[TCC_CMR_ACTS+8 +: 8], io_line_b_o);
            end
         end
      end
   end

   property p_ovf;
      @(posedge core_clk) disable iff (!nrst)
      cnt_step && !rst_pend && cnt == 16'hffff |=> cnt == 16'h0000 && sr[TCC_SR_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_zero;
      @(posedge core_clk) disable iff (!nrst)
      rst_pend && cnt_step |=> cnt == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("counter not zeroed");

   property p_off;
      @(posedge core_clk) disable iff (!nrst)
      off_cmd |=> !clk_en ##1 !cnt_upd;
   endproperty
   a_off: assert property (p_off) else $error("clock still enabled");

   property p_stop;
      @(posedge core_clk) disable iff (!nrst)
      clk_en && stop_ev |=> !clk_run;
   endproperty
   a_stop: assert property (p_stop) else $error("clock not stopped");

   property p_trig;
      @(posedge core_clk) disable iff (!nrst)
      clk_en && sw_trig && !stop_ev |=> clk_run && (rst_pend || cnt == 16'h0000);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger not applied");

   property p_ctrg;
      @(posedge core_clk) disable iff (!nrst)
      cmp_c && cmr[TCC_CMR_CTRG] |=> rst_pend;
   endproperty
   a_ctrg: assert property (p_ctrg) else $error("compare C no trigger");

   property p_seq;
      @(posedge core_clk) disable iff (!nrst)
      ld_a |=> phase == TCC_WAIT_B && ra == $past(cnt);
   endproperty
   a_seq: assert property (p_seq) else $error("load A sequence wrong");

   property p_ovr;
      @(posedge core_clk) disable iff (!nrst)
      ld_b && rb_unread |=> sr[TCC_SR_LOVR];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");

   property p_sticky;
      @(posedge core_clk) disable iff (!nrst)
      sr[TCC_SR_CPC] && !sr_read |=> sr[TCC_SR_CPC];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");

   property p_oe;
      @(posedge core_clk) disable iff (!nrst)
      !wave ##1 !wave |-> !io_line_a_oe && !io_line_b_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("line driven in capture");
endmodule

// >>> verification/tcc_ext_model.sv
// Behavioural far side: external clock pins, peer lines and the two I/O lines
`timescale 1ns/10ps
module tcc_ext_model (
   input wire logic core_clk,
   output logic [2:0] ext_clock_pin,
   output logic [2:0] peer_io_line_a,
   output logic line_a,
   output logic line_b
);
   logic run_clk;
   logic [1:0] hold;
   initial begin
      run_clk = 1'b0;
      hold = 2'h0;
      ext_clock_pin = 3'h0;
      peer_io_line_a = 3'h0;
      line_a = 1'b0;
      line_b = 1'b0;
   end
   // Levels held three master periods: slower than the 2.5 ratio with margin
   always @(posedge core_clk) begin
      if (run_clk) begin
         hold <= (hold == 2'h2) ? 2'h0 : hold + 2'h1;
         if (hold == 2'h2) begin
            ext_clock_pin[0] <= ~ext_clock_pin[0];
         end
      end
   end
   // Pulses always outlast one master period so the sampler cannot miss them
   task automatic pulse(input logic on_b, input int width);
      @(posedge core_clk);
      if (on_b) line_b <= 1'b1; else line_a <= 1'b1;
      repeat (width) @(posedge core_clk);
      if (on_b) line_b <= 1'b0; else line_a <= 1'b0;
      repeat (width) @(posedge core_clk);
   endtask
endmodule

// >>> verification/tb_tcc_channel.sv
// Self-checking bench for the timer/counter channel
`timescale 1ns/10ps
module tb_tcc_channel;
   import tcc_pkg::*;
   logic core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, d, v, r2;
   logic [2:0] ext_clock_pin, peer_io_line_a;
   logic mdl_a, mdl_b, io_line_a_o, io_line_a_oe, io_line_b_o, io_line_b_oe;
   int mismatches, comparisons, seed, n;
   logic [15:0] ra, rc;
   // Pin level: whoever enables wins, otherwise the far side drives
   wire pin_a = io_line_a_oe ? io_line_a_o : mdl_a;
   wire pin_b = io_line_b_oe ? io_line_b_o : mdl_b;
   tcc_channel i_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ext_clock_pin(ext_clock_pin), .peer_io_line_a(peer_io_line_a),
      .io_line_a_i(pin_a), .io_line_a_o(io_line_a_o), .io_line_a_oe(io_line_a_oe),
      .io_line_b_i(pin_b), .io_line_b_o(io_line_b_o), .io_line_b_oe(io_line_b_oe));
   tcc_ext_model i_model (.core_clk(core_clk), .ext_clock_pin(ext_clock_pin),
      .peer_io_line_a(peer_io_line_a), .line_a(mdl_a), .line_b(mdl_b));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] pwm_high(input logic [15:0] a, input logic [15:0] c);
      return 32'((c - a) * 2);
   endfunction
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic chk_rng(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      comparisons++;
      if (!(got >= lo && got <= hi)) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h..%h got=%h", $time, lo, hi, got);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then release
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rdat = wb_dat_o;
      if (k >= 50) begin
         mismatches++;
         report_and_stop();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      wb(1'b1, a, wd, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
      wb(1'b0, a, 32'h0, rdat);
   endtask
   task automatic wait_a(input logic lvl);
      n = 0;
      while (io_line_a_o !== lvl && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 400) begin
         mismatches++;
         $display("FAIL t=%0t exp=%h got=%h", $time, lvl, io_line_a_o);
         report_and_stop();
      end
   endtask
   initial begin
      repeat (100000) @(posedge core_clk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      seed = 69;
      mismatches = 0;
      comparisons = 0;
      nrst = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(TCC_CMR_OFS, d); chk(32'h0, d);
      rd(TCC_BMR_OFS, d); chk(32'h0, d);
      rd(TCC_SR_OFS, d); chk(32'h0, d);
      rd(8'h08, d); chk(32'h0, d);
      v = $random(seed);
      wr(TCC_CMR_OFS, v);
      rd(TCC_CMR_OFS, d); chk(v, d);
      wr(TCC_BMR_OFS, v);
      rd(TCC_BMR_OFS, d); chk({26'h0, v[5:0]}, d);
      // External clock from pin 0; enable alone must not start counting
      wr(TCC_BMR_OFS, 32'h0);
      wr(TCC_CMR_OFS, 32'h5);
      i_model.run_clk <= 1'b1;
      wr(TCC_CCR_OFS, 32'h1);
      repeat (60) @(posedge core_clk);
      rd(TCC_CV_OFS, d); chk(32'h0, d);
      rd(TCC_SR_OFS, d); chk(32'h1, 32'(d[16]));
      wr(TCC_CCR_OFS, 32'h4);
      repeat (120) @(posedge core_clk);
      rd(TCC_CV_OFS, d); chk_rng(32'd15, 32'd25, d);
      wr(TCC_BMR_OFS, 32'h1);
      rd(TCC_CV_OFS, v);
      repeat (60) @(posedge core_clk);
      rd(TCC_CV_OFS, d); chk(v, d);
      i_model.run_clk <= 1'b0;
      wr(TCC_CCR_OFS, 32'h3);
      rd(TCC_SR_OFS, d); chk(32'h0, 32'(d[16]));
      // Block-wide trigger on the /2 clock
      wr(TCC_CMR_OFS, 32'h0);
      wr(TCC_CCR_OFS, 32'h1);
      wr(TCC_BCR_OFS, 32'h1);
      repeat (40) @(posedge core_clk);
      rd(TCC_CV_OFS, d); chk_rng(32'd17, 32'd25, d);
      // Capture: A on rise, B on fall, trigger on line B rise
      // Compare C stays out of reach so its flag cannot join the load flags
      wr(TCC_RC_OFS, 32'h0000_ffff);
      wr(TCC_CMR_OFS, 32'h0009_0500);
      wr(TCC_CCR_OFS, 32'h5);
      rd(TCC_SR_OFS, d);
      i_model.pulse(1'b0, 40);
      rd(TCC_SR_OFS, d); chk(32'h60, 32'(d[7:0]));
      i_model.pulse(1'b0, 40);
      rd(TCC_SR_OFS, d); chk(32'h62, 32'(d[7:0]));
      rd(TCC_RA_OFS, v);
      rd(TCC_RB_OFS, r2);
      chk_rng(32'd19, 32'd21, r2 - v);
      i_model.pulse(1'b1, 10);
      rd(TCC_SR_OFS, d); chk(32'h1, 32'(d[7]));
      wr(TCC_CMR_OFS, 32'h0009_0080);
      wr(TCC_CCR_OFS, 32'h5);
      i_model.pulse(1'b0, 20);
      rd(TCC_SR_OFS, d); chk(32'h0, 32'(d[16]));
      // Waveform: A set on compare A, cleared on compare C which restarts
      ra = 16'(4 + $unsigned($random(seed)) % 12);
      rc = ra + 16'(6 + $unsigned($random(seed)) % 10);
      wr(TCC_CMR_OFS, 32'h0009_c400);
      wr(TCC_RA_OFS, {16'h0, ra});
      wr(TCC_RC_OFS, {16'h0, rc});
      wr(TCC_CCR_OFS, 32'h5);
      wait_a(1'b0);
      wait_a(1'b1);
      wait_a(1'b0);
      chk_rng(pwm_high(ra, rc) - 1, pwm_high(ra, rc) + 1, 32'(n));
      chk(32'h1, 32'(io_line_a_oe));
      chk(32'h1, 32'(io_line_b_oe));
      wr(TCC_CMR_OFS, 32'h0009_c000);
      repeat (2) @(posedge core_clk);
      chk(32'h0, 32'(io_line_b_oe));
      wr(TCC_CCR_OFS, 32'h2);
      rd(TCC_SR_OFS, d); chk(32'h14, 32'(d[7:0] & 8'h14));
      rd(TCC_SR_OFS, d); chk(32'h0, 32'(d[7:0]));
      // Soft trigger toggles both lines, line B driven
      wr(TCC_CMR_OFS, 32'hc0c0_8400);
      r2 = {30'h0, io_line_b_o, io_line_a_o};
      wr(TCC_CCR_OFS, 32'h4);
      chk({31'h0, ~r2[0]}, 32'(io_line_a_o));
      chk({31'h0, ~r2[1]}, 32'(io_line_b_o));
      report_and_stop();
   end
endmodule
